// File: design/msq_consts.svh
// Constants of the macro jog and speed sequencer: limits, defaults, timing.
// Assumes the includer also uses msq_pkg for the matching types.
`ifndef MSQ_CONSTS_SVH
`define MSQ_CONSTS_SVH
`define MSQ_CLK_HZ       28'hBEBC200
`define MSQ_MS_PER_S     32'h3E8
`define MSQ_TIME_MAX     13'h1388
`define MSQ_DEF_P2J      13'h01F4
`define MSQ_DEF_J2H      13'h03E8
`define MSQ_TRAVEL_MAX   23'h7FFFFF
`define MSQ_DEF_TRAVEL   23'h000001
`define MSQ_SPD_MAX      22'h3D0900
`define MSQ_DEF_JOG_SPD  22'h0003E8
`define MSQ_DEF_HIGH_SPD 22'h001388
`define MSQ_DEF_START    22'h0001F4
`define MSQ_DEF_OP_SPD   22'h0003E8
`define MSQ_RATE_MAX     30'h3B9ACA00
`define MSQ_DEF_RATE     30'h000F4240
`define MSQ_RATE_SHIFT   10
`define MSQ_TC_MAX       8'hC8
`define MSQ_DEF_TC       8'h01
`define MSQ_CUR_MAX      10'h3E8
`define MSQ_DEF_CUR      10'h3E8
`endif

// File: design/msq_pkg.sv
// Types shared by the sequencer and its speed ramp.
// Assumes the constants header for all limits and defaults.
package msq_pkg;
    typedef logic [21:0] msq_speed_t;
    typedef logic [29:0] msq_rate_t;
    typedef enum logic [2:0] {
        IDLE, INCH, CJ_INCH, CJ_JOG, CJ_HIGH, CONT, SPD, STOP
    } msq_state_t;
endpackage

// File: design/msq_ramp.sv
// Speed ramp, command filter and step generator of the sequencer.
// Assumes clean, range-checked settings from the sequencer.
`timescale 1ns/1ps
`include "msq_consts.svh"
module msq_ramp #(
    parameter int CYC_PER_MS = 200000
) (
    input  wire logic  clock,
    input  wire logic  reset_n,
    msq_ramp_if.ramp   rp
);
    logic [17:0]         ms_cnt, next_ms_cnt;
    msq_pkg::msq_speed_t ramp, next_ramp, filt, next_filt;
    logic [27:0]         acc, next_acc;
    logic                step, next_step, sdir, next_sdir;
    localparam logic [27:0] CLK_HZ = 28'(CYC_PER_MS * `MSQ_MS_PER_S);

    // Rate per millisecond, coarse division by a shift, never zero
    function automatic msq_pkg::msq_speed_t rate_step(msq_pkg::msq_rate_t r);
        msq_pkg::msq_rate_t t;
        t = r >> `MSQ_RATE_SHIFT;
        return (t == '0) ? 22'h000001 : t[21:0];
    endfunction

    // Filter weight from time constant, a cheap log2
    function automatic logic [2:0] tc_shift(logic [7:0] tc);
        logic [2:0] s;
        s = 3'h0;
        for (int i = 1; i < 8; i++)
            if (tc[i]) s = 3'(i);
        return s;
    endfunction

    assign rp.speed    = filt;
    assign rp.at_rest  = (ramp == '0) && (filt == '0);
    assign rp.ms_tick  = (ms_cnt == 18'(CYC_PER_MS - 1));
    assign rp.step     = step;
    assign rp.step_dir = sdir;

    // Next ramp, filter and step phase
    always_comb begin
        msq_pkg::msq_speed_t up, dn, diff, d;
        logic [28:0]         sum;
        up = rate_step(rp.accel);
        dn = rate_step(rp.decel);
        diff = '0;
        d = '0;
        sum = '0;
        next_ms_cnt = rp.ms_tick ? '0 : ms_cnt + 18'h00001;
        next_ramp = ramp;
        next_filt = filt;
        next_sdir = sdir;
        if (rp.run && ramp == '0 && filt == '0)
            next_sdir = rp.dir; // Reversal only from rest
        if (rp.halt) begin
            next_ramp = '0;
        end else if (rp.ms_tick && rp.run) begin
            if (ramp == '0 && rp.start_spd != '0) begin
                // Jump to starting speed, capped at target
                next_ramp = (rp.start_spd > rp.target) ? rp.target
                                                       : rp.start_spd;
            end else if (ramp < rp.target) begin
                next_ramp = (rp.target - ramp < up) ? rp.target
                                                    : ramp + up;
            end else if (ramp > rp.target) begin
                next_ramp = (ramp - rp.target < up) ? rp.target
                                                    : ramp - up;
            end
        end else if (rp.ms_tick) begin
            // Stop deceleration, cut at starting speed
            next_ramp = (ramp <= dn || ramp <= rp.start_spd) ? '0
                                                             : ramp - dn;
        end
        // One-pole command filter, always creeps to the ramp
        if (rp.halt) begin
            next_filt = '0;
        end else if (rp.ms_tick) begin
            diff = (ramp > filt) ? ramp - filt : filt - ramp;
            d = diff >> tc_shift(rp.tc);
            if (d == '0 && diff != '0) d = 22'h000001;
            next_filt = (ramp > filt) ? filt + d : filt - d;
        end
        // Phase accumulator turns speed in Hz into steps
        sum = {1'b0, acc} + {7'h00, filt};
        next_step = rp.halt ? 1'b0 : (sum >= {1'b0, CLK_HZ});
        if (rp.halt)
            next_acc = '0;
        else if (next_step)
            next_acc = sum[27:0] - CLK_HZ;
        else
            next_acc = sum[27:0];
    end

    // Ramp state registers
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ms_cnt <= '0;
            ramp   <= '0;
            filt   <= '0;
            acc    <= '0;
            step   <= 1'b0;
            sdir   <= 1'b0;
        end else begin
            ms_cnt <= next_ms_cnt;
            ramp   <= next_ramp;
            filt   <= next_filt;
            acc    <= next_acc;
            step   <= next_step;
            sdir   <= next_sdir;
        end
    end
endmodule // msq_ramp

// File: design/msq_ramp_if.sv
// Link between the sequencer state machine and its speed ramp.
// Assumes both ends share one clock and reset.
`timescale 1ns/1ps
interface msq_ramp_if;
    logic                run;
    logic                halt;
    logic                dir;
    msq_pkg::msq_speed_t target;
    msq_pkg::msq_rate_t  accel;
    msq_pkg::msq_rate_t  decel;
    msq_pkg::msq_speed_t start_spd;
    logic [7:0]          tc;
    msq_pkg::msq_speed_t speed;
    logic                at_rest;
    logic                ms_tick;
    logic                step;
    logic                step_dir;
    modport seq  (output run, halt, dir, target, accel, decel, start_spd,
                  tc, input speed, at_rest, ms_tick, step, step_dir);
    modport ramp (input run, halt, dir, target, accel, decel, start_spd,
                  tc, output speed, at_rest, ms_tick, step, step_dir);
endinterface

// File: design/msq_sequencer.sv
// Macro jog and speed sequencer: combined jog, inching, continuous and
// speed-control operation of a stepping motor driver.
// Assumes settings are held steady outside by stored configuration.
// How it works
// - Held combined jog runs inching, normal jog, high jog; release stops.
// - Inching changes to normal jog after first delay, 500 ms default.
// - Normal jog changes to high jog after second delay, 1000 ms default.
// - On start, ready drops and moving rises before motion.
// - Once stopped and at rest, ready rises and moving falls.
// - Inching travel 1 to 8388607 steps, default 1.
// - Inching and normal jog share one speed, default 1000 Hz.
// - High-speed jog has its own speed, default 5000 Hz.
// - Jog modes share one acceleration and deceleration rate.
// - Jog modes start at a starting speed, default 500 Hz.
// - Jog command smoothed by filter, 1 to 200 ms time constant.
// - Continuous mode runs at selected entry speed while input held.
// - Changing selected entry changes speed without stopping.
// - Release decelerates; same direction reasserted accelerates again.
// - Both continuous inputs together decelerate to stop.
// - Speed-control runs at selected speed, follows entry changes.
// - Speed-control stops on both inputs; release behaves as continuous.
// - Entry speed signed, -4000000 to 4000000 Hz, default 1000.
// - Entry starting and changing rate, default 1000000.
// - Entry stopping deceleration rate, default 1000000.
// - Entry operating current 0 to 1000 of base, default 1000.
// - Inching input rising edge moves travel amount, then stops.
`timescale 1ns/1ps
`include "msq_consts.svh"
module msq_sequencer #(
    parameter int CYC_PER_MS = `MSQ_CLK_HZ / `MSQ_MS_PER_S
) (
    input  wire logic        clock,
    input  wire logic        reset_n,
    input  wire logic        fwd_combined_jog_in,
    input  wire logic        rev_combined_jog_in,
    input  wire logic        fwd_continuous_in,
    input  wire logic        rev_continuous_in,
    input  wire logic        fwd_speed_ctrl_in,
    input  wire logic        rev_speed_ctrl_in,
    input  wire logic        fwd_inching_in,
    input  wire logic        rev_inching_in,
    input  wire logic [12:0] jogc_inch_to_jog_ms,
    input  wire logic [12:0] jogc_jog_to_high_ms,
    input  wire logic [22:0] jog_travel,
    input  wire logic [21:0] jog_speed,
    input  wire logic [21:0] jog_high_speed,
    input  wire logic [29:0] jog_accel,
    input  wire logic [21:0] jog_start_speed,
    input  wire logic [7:0]  jog_filter_ms,
    input  wire logic [9:0]  jog_current,
    input  wire logic [21:0] base_start_speed,
    input  wire logic [22:0] op_speed,
    input  wire logic [29:0] op_rate,
    input  wire logic [29:0] op_decel,
    input  wire logic [9:0]  op_current,
    output logic             ready,
    output logic             moving,
    output logic             inching_phase,
    output logic             high_speed_jog_phase,
    output logic             step_pulse,
    output logic             step_dir,
    output logic [21:0]      cur_speed,
    output logic [9:0]       drive_current
);
    msq_ramp_if rp ();

    logic [7:0]          s1, s2, s3, clean, next_clean, prev, next_prev;
    msq_pkg::msq_state_t state, next_state;
    logic                dir, next_dir, inch_done, next_inch_done;
    logic [12:0]         timer, next_timer;
    logic [22:0]         steps, next_steps;
    logic                next_ready, next_hs;
    logic [9:0]          next_cur;
    logic                step_q, sdir_q;
    logic [21:0]         speed_q;
    logic                cj_f, cj_r, ct_f, ct_r, sc_f, sc_r, in_f, in_r;
    logic                cont_mode, next_cont_mode;

    // Out-of-range speed falls back to its default
    function automatic msq_pkg::msq_speed_t fix_spd(
        msq_pkg::msq_speed_t v, msq_pkg::msq_speed_t d, logic zero_ok);
        return ((v == '0 && !zero_ok) || v > `MSQ_SPD_MAX) ? d : v;
    endfunction

    // Out-of-range rate falls back to its default
    function automatic msq_pkg::msq_rate_t fix_rate(msq_pkg::msq_rate_t v);
        return (v == '0 || v > `MSQ_RATE_MAX) ? `MSQ_DEF_RATE : v;
    endfunction

    // Out-of-range delay falls back to its default
    function automatic logic [12:0] fix_time(logic [12:0] v,
                                             logic [12:0] d);
        return (v == '0 || v > `MSQ_TIME_MAX) ? d : v;
    endfunction

    // Out-of-range current falls back to full base current
    function automatic logic [9:0] fix_cur(logic [9:0] v);
        return (v > `MSQ_CUR_MAX) ? `MSQ_DEF_CUR : v;
    endfunction

    // Clean level per input, pin noise filtered by agreement
    assign {cj_f, cj_r, ct_f, ct_r, sc_f, sc_r, in_f, in_r} = clean;

    // Synchroniser and debounce; s1 feeds s2 only
    always_comb begin
        next_clean = (clean & ~(s2 ~^ s3)) | (s3 & (s2 ~^ s3));
        next_prev  = clean;
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            s1    <= '0;
            s2    <= '0;
            s3    <= '0;
            clean <= '0;
            prev  <= '0;
        end else begin
            s1    <= {fwd_combined_jog_in, rev_combined_jog_in,
                      fwd_continuous_in, rev_continuous_in,
                      fwd_speed_ctrl_in, rev_speed_ctrl_in,
                      fwd_inching_in, rev_inching_in};
            s2    <= s1;
            s3    <= s2;
            clean <= next_clean;
            prev  <= next_prev;
        end
    end

    // Ramp settings follow the running mode
    always_comb begin
        logic [21:0] op_mag;
        op_mag = op_speed[22] ? 22'(-op_speed) : op_speed[21:0];
        rp.run = 1'b0;
        rp.halt = 1'b0;
        rp.dir = dir;
        rp.target = fix_spd(jog_speed, `MSQ_DEF_JOG_SPD, 1'b0);
        rp.accel = fix_rate(jog_accel);
        rp.decel = fix_rate(jog_accel);
        rp.start_spd = fix_spd(jog_start_speed, `MSQ_DEF_START, 1'b1);
        rp.tc = (jog_filter_ms == '0 || jog_filter_ms > `MSQ_TC_MAX)
                ? `MSQ_DEF_TC : jog_filter_ms;
        case (state)
            msq_pkg::INCH, msq_pkg::CJ_INCH: begin
                rp.run  = !inch_done;
                rp.halt = inch_done; // Exact travel, no overshoot
            end
            msq_pkg::CJ_JOG:
                rp.run = 1'b1;
            msq_pkg::CJ_HIGH: begin
                rp.run = 1'b1;
                rp.target = fix_spd(jog_high_speed, `MSQ_DEF_HIGH_SPD,
                                    1'b0);
            end
            default:
                rp.run = (state == msq_pkg::CONT) || (state == msq_pkg::SPD);
        endcase
        if (cont_mode) begin
            // Selected entry drives speed and rates
            rp.target = fix_spd(op_mag, `MSQ_DEF_OP_SPD, 1'b1);
            rp.dir = dir ^ op_speed[22];
            rp.accel = fix_rate(op_rate);
            rp.decel = fix_rate(op_decel);
            rp.start_spd = fix_spd(base_start_speed, `MSQ_DEF_START, 1'b1);
            rp.tc = `MSQ_DEF_TC;
        end
    end

    msq_ramp #(
        .CYC_PER_MS (CYC_PER_MS)
    ) u_ramp (
        .clock   (clock),
        .reset_n (reset_n),
        .rp      (rp)
    );

    // Mode sequencing
    always_comb begin
        next_state = state;
        next_dir = dir;
        next_cont_mode = cont_mode;
        next_inch_done = inch_done;
        next_timer = timer;
        next_steps = steps;
        if (rp.step && steps != '1)
            next_steps = steps + 23'h000001;
        if (rp.ms_tick && timer != '1)
            next_timer = timer + 13'h0001;
        if (inching_phase &&
            next_steps >= ((jog_travel == '0) ? `MSQ_DEF_TRAVEL
                                              : jog_travel))
            next_inch_done = 1'b1;
        case (state)
            msq_pkg::IDLE: begin
                next_steps = '0;
                next_timer = '0;
                next_inch_done = 1'b0;
                next_cont_mode = 1'b0;
                // Starts only from rest; host waits for ready
                if (rp.at_rest) begin
                    if (cj_f ^ cj_r) begin
                        next_state = msq_pkg::CJ_INCH;
                        next_dir = cj_r;
                    end else if (cj_f && cj_r) begin
                        next_state = msq_pkg::IDLE; // Both held
                    end else if (ct_f ^ ct_r) begin
                        next_state = msq_pkg::CONT;
                        next_dir = ct_r;
                        next_cont_mode = 1'b1;
                    end else if (sc_f ^ sc_r) begin
                        next_state = msq_pkg::SPD;
                        next_dir = sc_r;
                        next_cont_mode = 1'b1;
                    end else if ((in_f && !prev[1]) ||
                                 (in_r && !prev[0])) begin
                        next_state = msq_pkg::INCH; // Rising edge only
                        next_dir = in_r && !prev[0] && !in_f;
                    end
                end
            end
            msq_pkg::INCH:
                if (inch_done && rp.at_rest)
                    next_state = msq_pkg::IDLE;
            msq_pkg::CJ_INCH, msq_pkg::CJ_JOG, msq_pkg::CJ_HIGH: begin
                if (!(cj_f ^ cj_r)) begin
                    next_state = msq_pkg::STOP; // Release or both
                end else if (state == msq_pkg::CJ_INCH && timer >=
                    fix_time(jogc_inch_to_jog_ms, `MSQ_DEF_P2J)) begin
                    next_state = msq_pkg::CJ_JOG;
                    next_timer = '0;
                end else if (state == msq_pkg::CJ_JOG && timer >=
                    fix_time(jogc_jog_to_high_ms, `MSQ_DEF_J2H)) begin
                    next_state = msq_pkg::CJ_HIGH;
                end
            end
            msq_pkg::CONT:
                if ((ct_f && ct_r) || (dir ? !ct_r : !ct_f))
                    next_state = msq_pkg::STOP;
            msq_pkg::SPD:
                if ((sc_f && sc_r) || (dir ? !sc_r : !sc_f))
                    next_state = msq_pkg::STOP;
            default: begin
                // Same direction alone resumes during deceleration
                if (cont_mode && !steps[0] && rp.speed != '0 &&
                    state == msq_pkg::STOP) begin
                    if (ct_f ^ ct_r && ct_r == dir && !sc_f && !sc_r)
                        next_state = msq_pkg::CONT;
                    else if (sc_f ^ sc_r && sc_r == dir && !ct_f && !ct_r)
                        next_state = msq_pkg::SPD;
                end
                if (rp.at_rest)
                    next_state = msq_pkg::IDLE;
            end
        endcase
        if (cont_mode)
            next_steps = '0; // Step count unused outside inching
        // Status follows the coming state
        next_ready = (next_state == msq_pkg::IDLE) && rp.at_rest &&
                     (state == msq_pkg::IDLE || state == msq_pkg::STOP ||
                      state == msq_pkg::INCH);
        next_hs = (next_state == msq_pkg::CJ_HIGH);
        next_cur = fix_cur(next_cont_mode ? op_current : jog_current);
    end

    // Sequencer registers and registered outputs
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state                <= msq_pkg::IDLE;
            dir                  <= 1'b0;
            cont_mode            <= 1'b0;
            inch_done            <= 1'b0;
            timer                <= '0;
            steps                <= '0;
            ready                <= 1'b0;
            moving               <= 1'b0;
            inching_phase        <= 1'b0;
            high_speed_jog_phase <= 1'b0;
            drive_current        <= '0;
            step_q               <= 1'b0;
            sdir_q               <= 1'b0;
            speed_q              <= '0;
        end else begin
            state                <= next_state;
            dir                  <= next_dir;
            cont_mode            <= next_cont_mode;
            inch_done            <= next_inch_done;
            timer                <= next_timer;
            steps                <= next_steps;
            ready                <= next_ready;
            moving               <= !next_ready;
            inching_phase        <= (next_state == msq_pkg::CJ_INCH) ||
                                    (next_state == msq_pkg::INCH);
            high_speed_jog_phase <= next_hs;
            drive_current        <= next_cur;
            step_q               <= rp.step;
            sdir_q               <= rp.step_dir;
            speed_q              <= rp.speed;
        end
    end

    assign step_pulse = step_q;
    assign step_dir   = sdir_q;
    assign cur_speed  = speed_q;
endmodule // msq_sequencer

// File: test/msq_host_model.sv
// Host model: drives the eight direction inputs of the sequencer.
// Assumes the bench states wanted levels on want, combined jog in bit 7.
`timescale 1ns/1ps
module msq_host_model (
    input  wire logic       clock,
    input  wire logic       ready,
    input  wire logic       resume,
    input  wire logic [7:0] want,
    output logic      [7:0] dir_in
);
    logic [7:0] w;
    logic       ok;
    initial dir_in = 8'h00;
    // New starts wait for ready; resume in a stop is a bench order only
    always @(posedge clock) begin
        w = want;
        ok = ready || resume || (|dir_in);
        #1;
        dir_in <= w & (dir_in | {8{ok}});
    end
endmodule // msq_host_model

// File: test/msq_sequencer_sva.sv
// Checker of the sequencer status and motion outputs.
// Assumes it is bound to msq_sequencer, one clock domain.
`timescale 1ns/1ps
module msq_sequencer_sva (
    input wire logic        clock,
    input wire logic        reset_n,
    input wire logic        fwd_combined_jog_in,
    input wire logic        rev_combined_jog_in,
    input wire logic        fwd_continuous_in,
    input wire logic        rev_continuous_in,
    input wire logic        fwd_inching_in,
    input wire logic        ready,
    input wire logic        moving,
    input wire logic        inching_phase,
    input wire logic        high_speed_jog_phase,
    input wire logic        step_pulse,
    input wire logic        step_dir,
    input wire logic [21:0] cur_speed
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    // Status pair; first edge after reset still shows reset values
    property p_pair; $past(reset_n) |-> moving != ready; endproperty
    a_pair: assert property (p_pair) else $error("ready equals moving");
    property p_rest; ready |-> cur_speed == 22'h000000; endproperty
    a_rest: assert property (p_rest) else $error("ready while moving");
    property p_cont;
        $rose(fwd_continuous_in) && ready && !rev_continuous_in
            && !fwd_combined_jog_in |-> ##[1:8] !ready;
    endproperty
    a_cont: assert property (p_cont) else $error("no start");
    property p_cj;
        $rose(fwd_combined_jog_in) && ready && !rev_combined_jog_in
            |-> ##[1:8] (inching_phase && moving);
    endproperty
    a_cj: assert property (p_cj) else $error("no inching first");
    property p_inch; $rose(fwd_inching_in) && ready |-> ##[1:8] inching_phase;
    endproperty
    a_inch: assert property (p_inch) else $error("no inching move");
    property p_high; high_speed_jog_phase |-> moving && !inching_phase;
    endproperty
    a_high: assert property (p_high) else $error("bad high phase");
    property p_step; step_pulse |-> !ready; endproperty
    a_step: assert property (p_step) else $error("step while ready");
    // Direction may only turn over with the motor at rest
    property p_dir; $changed(step_dir) |-> $past(cur_speed) == 22'h000000;
    endproperty
    a_dir: assert property (p_dir) else $error("dir change in motion");
    property p_both;
        (fwd_continuous_in && rev_continuous_in && ready
            && !fwd_combined_jog_in) [*4] |=> ready;
    endproperty
    a_both: assert property (p_both) else $error("start on both");
    property p_cjb; (fwd_combined_jog_in && rev_combined_jog_in && ready) [*4]
        |=> ready; endproperty
    a_cjb: assert property (p_cjb) else $error("jog start on both");
    c_high: cover property (high_speed_jog_phase);
    c_both: cover property (fwd_continuous_in && rev_continuous_in && moving);
    c_done: cover property ($rose(ready));
endmodule // msq_sequencer_sva

// File: test/tb_top.sv
// Bench of the macro jog and speed sequencer with a host model.
// Assumes a 200 MHz clock and a shortened millisecond of CPM cycles.
`timescale 1ns/1ps
module tb_top;
    localparam int CPM = 20;
    logic        clock = 1'b0;
    logic        reset_n = 1'b0;
    logic        resume = 1'b0;
    logic [7:0]  want = 8'h00;
    wire         fwd_combined_jog_in, rev_combined_jog_in, fwd_continuous_in;
    wire         rev_continuous_in, fwd_speed_ctrl_in, rev_speed_ctrl_in;
    wire         fwd_inching_in, rev_inching_in;
    logic [12:0] jogc_inch_to_jog_ms = 13'h0003;
    logic [12:0] jogc_jog_to_high_ms = 13'h0002;
    logic [22:0] jog_travel = 23'h000003;
    logic [21:0] jog_speed = 22'h000064;
    logic [21:0] jog_high_speed = 22'h0000C8;
    logic [29:0] jog_accel = 30'h00019000; // 100 Hz per tick
    logic [21:0] jog_start_speed = 22'h000032;
    logic [7:0]  jog_filter_ms = 8'h01;
    logic [9:0]  jog_current = 10'h1F4;
    logic [21:0] base_start_speed = 22'h000032;
    logic [22:0] op_speed = 23'h000064;
    logic [29:0] op_rate = 30'h00019000;
    logic [29:0] op_decel = 30'h0000C800; // Slow stop leaves room to resume
    logic [9:0]  op_current = 10'h3E8;
    logic        ready, moving, inching_phase, high_speed_jog_phase;
    logic        step_pulse, step_dir;
    logic [21:0] cur_speed;
    logic [9:0]  drive_current;
    int          error_cnt = 0;
    int          compares = 0;
    int          steps = 0;
    int          n, m;
    always #2.5 clock = ~clock;
    msq_host_model i_msq_host_model (.clock, .ready, .resume, .want,
        .dir_in({fwd_combined_jog_in, rev_combined_jog_in, fwd_continuous_in,
                 rev_continuous_in, fwd_speed_ctrl_in, rev_speed_ctrl_in,
                 fwd_inching_in, rev_inching_in}));
    msq_sequencer #(.CYC_PER_MS(CPM)) i_msq_sequencer (.clock, .reset_n,
        .fwd_combined_jog_in, .rev_combined_jog_in, .fwd_continuous_in,
        .rev_continuous_in, .fwd_speed_ctrl_in, .rev_speed_ctrl_in,
        .fwd_inching_in, .rev_inching_in, .jogc_inch_to_jog_ms,
        .jogc_jog_to_high_ms, .jog_travel, .jog_speed, .jog_high_speed,
        .jog_accel, .jog_start_speed, .jog_filter_ms, .jog_current,
        .base_start_speed, .op_speed, .op_rate, .op_decel, .op_current,
        .ready, .moving, .inching_phase, .high_speed_jog_phase, .step_pulse,
        .step_dir, .cur_speed, .drive_current);
    // Step counter for the inching travel
    always @(posedge clock) if (step_pulse === 1'b1) steps++;
    task automatic cmp(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s exp %0h got %0h", nm, e, g);
        end
    endtask
    task automatic report_and_stop();
        $display("Compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    function automatic logic hit(input int s);
        case (s)
            0: hit = ready;
            1: hit = !ready;
            2: hit = !inching_phase;
            3: hit = high_speed_jog_phase;
            4: hit = cur_speed == 22'h000064;
            default: hit = cur_speed == 22'h0000C8;
        endcase
    endfunction
    // Bounded wait, sampled one step after the edge
    task automatic wait_on(input int s, output int c);
        c = 0;
        while (hit(s) !== 1'b1) begin
            @(posedge clock);
            #1;
            c++;
            if (c > 40000) begin
                error_cnt++;
                $display("BAD wait %0d exp 1 got 0", s);
                report_and_stop();
            end
        end
    endtask
    initial begin
        repeat (4) @(posedge clock);
        #1 reset_n = 1'b1;
        wait_on(0, n);
        want = 8'h80;
        wait_on(1, n);
        cmp("inching_phase", 1, inching_phase);
        cmp("drive_current", 10'h1F4, drive_current);
        wait_on(2, n);
        cmp("p2j_window", 1, n >= 2 * CPM && n <= 4 * CPM + 8);
        wait_on(4, m);
        wait_on(3, n);
        cmp("j2h_window", 1, m + n >= CPM && m + n <= 3 * CPM + 8);
        wait_on(5, n);
        want = 8'h00;
        wait_on(0, n);
        cmp("moving", 0, moving);
        $display("Test combined jog done");
        want = 8'h20;
        wait_on(4, n);
        cmp("cont_ready", 0, ready);
        op_speed = 23'h0000C8;
        wait_on(5, n);
        cmp("change_ready", 0, ready);
        want = 8'h00;
        repeat (10) @(posedge clock);
        #1 resume = 1'b1;
        want = 8'h20;
        cmp("in_stop", 1, cur_speed != 22'h0 && !ready);
        wait_on(5, n);
        cmp("resumed", 0, ready);
        resume = 1'b0;
        want = 8'h30;
        wait_on(0, n);
        repeat (8) @(posedge clock);
        cmp("both_cont", 1, ready && !moving);
        want = 8'h00;
        $display("Test continuous done");
        op_speed = 23'h7FFF38;
        want = 8'h08;
        wait_on(5, n);
        cmp("rev_dir", 1, step_dir);
        want = 8'h0C;
        wait_on(0, n);
        cmp("both_spd", 0, moving);
        want = 8'h00;
        $display("Test speed control done");
        steps = 0;
        want = 8'h02;
        wait_on(1, n);
        want = 8'h00;
        wait_on(0, n);
        cmp("inch_steps", 3, steps);
        $display("Test inching done");
        want = 8'hC0;
        repeat (12) @(posedge clock);
        cmp("both_jog", 1, ready);
        want = 8'h00;
        $display("Test both jog done");
        report_and_stop();
    end
endmodule // tb_top
bind msq_sequencer msq_sequencer_sva i_msq_sequencer_sva (.clock, .reset_n,
    .fwd_combined_jog_in, .rev_combined_jog_in, .fwd_continuous_in,
    .rev_continuous_in, .fwd_inching_in, .ready, .moving, .inching_phase,
    .high_speed_jog_phase, .step_pulse, .step_dir, .cur_speed);
